// ---- common/cal_pkg.sv ----
// constants, register map and types for the self-calibration sequencer
package cal_pkg;
  localparam int ADDR_W = 15;

  // register offsets
  localparam logic [14:0] ADDR_IRQ_ENABLE  = 15'h01f;
  localparam logic [14:0] ADDR_IRQ_STATUS  = 15'h023;
  localparam logic [14:0] ADDR_AVG_CTRL    = 15'h0e2;
  localparam logic [14:0] ADDR_CLK_CFG     = 15'h0e7;
  localparam logic [14:0] ADDR_CH_SELECT   = 15'h0e8;
  localparam logic [14:0] ADDR_CH_CTRL     = 15'h0e9;
  localparam logic [14:0] ADDR_INIT_VALUE  = 15'h0ed;

  // field positions
  localparam int PASS_BIT    = 7;
  localparam int FAIL_BIT    = 6;
  localparam int DONE_BIT    = 7;
  localparam int ERR_LSB     = 4;
  localparam int ENABLE_BIT  = 0;
  localparam int START_BIT   = 1;
  localparam int CLK_RUN_BIT = 3;
  localparam int NUM_CH      = 4;

  // reset values
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_CLK_CFG    = 8'h30;
  localparam logic [3:0] RST_CH_SELECT  = 4'h0;
  localparam logic [7:0] RST_INIT_VALUE = 8'h00;

  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CAL_TIME_NS   = 2000;
  localparam int CAL_CYCLES    = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // serial frame layout
  localparam logic [4:0] SPI_INSTR_BITS = 5'h10;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h18;

  typedef enum logic [1:0] {MODE_IDLE, MODE_AVG, MODE_CHAN} cal_mode_t;
endpackage : cal_pkg

// ---- common/cal_reg_if.sv ----
// register access path between the serial port and the sequencer
`timescale 1ns/1ps
interface cal_reg_if;
  import cal_pkg::*;
  logic              wr_stb;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : cal_reg_if

// ---- logic/spi_reg_port.sv ----
// serial register port: 16-bit instruction then one data byte
`timescale 1ns/1ps
module spi_reg_port (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // serial pins
  input  wire logic sclk,
  input  wire logic cs_b,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe_b,
  // register side
  cal_reg_if.port   bus
);
  import cal_pkg::*;

  typedef struct packed {
    logic [2:0]        sync_sclk;
    logic [2:0]        sync_cs;
    logic [2:0]        sync_sdi;
    logic              sclk_st;
    logic              cs_st;
    logic [4:0]        cnt;
    logic [15:0]       shift;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        dout;
    logic              sdo;
    logic              wr;
  } spi_state_t;

  spi_state_t s;
  spi_state_t next_s;

  always_comb begin
    logic rise;
    logic fall;
    logic din;
    rise = 1'b0;
    fall = 1'b0;
    din  = s.sync_sdi[2];
    next_s = s;
    next_s.sync_sclk = {s.sync_sclk[1:0], sclk};
    next_s.sync_cs   = {s.sync_cs[1:0], cs_b};
    next_s.sync_sdi  = {s.sync_sdi[1:0], sdi};
    next_s.wr = 1'b0;
    // a change counts only once the last two stages agree
    if (s.sync_sclk[2] == s.sync_sclk[1] && s.sync_sclk[2] != s.sclk_st) begin
      next_s.sclk_st = s.sync_sclk[2];
      rise = s.sync_sclk[2];
      fall = !s.sync_sclk[2];
    end
    if (s.sync_cs[2] == s.sync_cs[1]) begin
      next_s.cs_st = s.sync_cs[2];
    end
    if (s.cs_st) begin
      next_s.cnt = 5'd0;
      next_s.rd  = 1'b0;
    end else if (rise && s.cnt < SPI_FRAME_BITS) begin
      next_s.cnt = s.cnt + 5'd1;
      if (s.cnt < SPI_INSTR_BITS) begin
        next_s.shift = {s.shift[14:0], din};
        if (s.cnt == SPI_INSTR_BITS - 5'd1) begin
          next_s.rd   = s.shift[14];
          next_s.addr = {s.shift[13:0], din};
        end
      end else if (!s.rd) begin
        next_s.dout = {s.dout[6:0], din};
        next_s.wr   = (s.cnt == SPI_FRAME_BITS - 5'd1);
      end
    end else if (fall && s.rd && s.cnt >= SPI_INSTR_BITS && s.cnt < SPI_FRAME_BITS) begin
      // first falling edge of the data phase loads the read byte
      if (s.cnt == SPI_INSTR_BITS) begin
        next_s.sdo  = bus.rdata[7];
        next_s.dout = {bus.rdata[6:0], 1'b0};
      end else begin
        next_s.sdo  = s.dout[7];
        next_s.dout = {s.dout[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{sync_sclk: 3'h0, sync_cs: 3'h7, sync_sdi: 3'h0, sclk_st: 1'b0, cs_st: 1'b1,
             cnt: 5'h0, shift: 16'h0, rd: 1'b0, addr: '0, dout: 8'h0, sdo: 1'b0,
             wr: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign bus.wr_stb = s.wr;
  assign bus.addr   = s.addr;
  assign bus.wdata  = s.dout;
  assign sdo        = s.sdo;
  // enabled from the 16th rise so the first data bit is driven before it is sampled
  assign sdo_oe_b   = !(!s.cs_st && s.rd && s.cnt >= SPI_INSTR_BITS);
endmodule : spi_reg_port

// ---- logic/dac_self_calibration_ctrl.sv ----
// self-calibration sequencer for a four-channel converter with its register set
// How it works
// - select register bits 3..0 choose channels
// - pass bit7, fail bit6; zero while running
// - select channel, read done bit7, errors 6:4
// - pass/fail events gated by enable bits 7:6
// - one completed run gives full result
`timescale 1ns/1ps
module dac_self_calibration_ctrl (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // serial port
  input  wire logic sclk,
  input  wire logic cs_b,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe_b,
  // analog calibration engine
  input  wire logic [cal_pkg::NUM_CH-1:0] cmp_fault,
  output logic                            cal_clk_en,
  output logic                            cal_busy,
  output logic [cal_pkg::NUM_CH-1:0]      cal_active_ch,
  output logic [7:0]                      cal_init_value,
  // event output
  output logic                            irq
);
  import cal_pkg::*;

  typedef struct packed {
    logic [7:0]              irq_en;
    logic                    pass;
    logic                    fail;
    logic                    avg_en;
    logic                    ch_en;
    logic [7:0]              clk_cfg;
    logic [NUM_CH-1:0]       sel;
    logic [7:0]              init;
    cal_mode_t               mode;
    logic [15:0]             cnt;
    logic [NUM_CH-1:0]       run_sel;
    logic [NUM_CH-1:0]       fault_seen;
    logic [NUM_CH-1:0]       done;
    logic [NUM_CH-1:0][2:0]  err;
  } cal_state_t;

  cal_state_t s;
  cal_state_t next_s;

  cal_reg_if bus ();

  spi_reg_port u_spi (
    .clk      (clk),
    .rst_b    (rst_b),
    .sclk     (sclk),
    .cs_b     (cs_b),
    .sdi      (sdi),
    .sdo      (sdo),
    .sdo_oe_b (sdo_oe_b),
    .bus      (bus.port)
  );

  logic                    clk_on;
  logic                    running;
  logic                    abort;
  logic                    finish;
  logic [NUM_CH-1:0]       fault_now;
  logic                    set_pass;
  logic                    set_fail;
  logic                    start_avg;
  logic                    start_ch;
  logic                    start;
  logic [NUM_CH-1:0]       done_n;
  logic [NUM_CH-1:0][2:0]  err_n;
  logic [1:0]              rd_idx;

  assign clk_on    = s.clk_cfg[CLK_RUN_BIT];
  assign running   = (s.mode != MODE_IDLE);
  // clock pulled mid-run ends the run as a failure rather than hanging
  assign abort     = running && !clk_on;
  assign finish    = running && (abort || s.cnt == 16'h0);
  assign fault_now = s.fault_seen | (cmp_fault & s.run_sel);
  assign set_pass  = finish && !abort && (fault_now == '0);
  assign set_fail  = finish && !set_pass;
  // start only from idle with enable and start both written
  assign start_avg = bus.wr_stb && bus.addr == ADDR_AVG_CTRL && !running
                     && bus.wdata[ENABLE_BIT] && bus.wdata[START_BIT];
  assign start_ch  = bus.wr_stb && bus.addr == ADDR_CH_CTRL && !running
                     && bus.wdata[ENABLE_BIT] && bus.wdata[START_BIT];
  assign start     = start_avg || start_ch;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      always_comb begin
        done_n[gi] = s.done[gi];
        err_n[gi]  = s.err[gi];
        if (start && s.sel[gi]) begin
          done_n[gi] = 1'b0;
          err_n[gi]  = 3'h0;
        end else if (finish && s.run_sel[gi]) begin
          done_n[gi] = 1'b1;
          err_n[gi]  = {1'b0, abort, fault_now[gi]};
        end
      end
    end
  endgenerate

  // status reads report the lowest selected channel
  always_comb begin
    rd_idx = 2'd0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (s.sel[i]) begin
        rd_idx = 2'(i);
      end
    end
  end

  always_comb begin
    bus.rdata = 8'h00;
    unique case (bus.addr)
      ADDR_IRQ_ENABLE: bus.rdata = s.irq_en;
      ADDR_IRQ_STATUS: bus.rdata = {s.pass, s.fail, 6'h00};
      ADDR_AVG_CTRL:   bus.rdata = {6'h00, running && s.mode == MODE_AVG, s.avg_en};
      ADDR_CLK_CFG:    bus.rdata = s.clk_cfg;
      ADDR_CH_SELECT:  bus.rdata = {4'h0, s.sel};
      ADDR_CH_CTRL:    bus.rdata = {s.done[rd_idx], s.err[rd_idx], 2'h0,
                                    running && s.mode == MODE_CHAN, s.ch_en};
      ADDR_INIT_VALUE: bus.rdata = s.init;
      default:         bus.rdata = 8'h00;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.done = done_n;
    next_s.err  = err_n;
    if (running) begin
      next_s.fault_seen = fault_now;
      if (clk_on && s.cnt != 16'h0) begin
        next_s.cnt = s.cnt - 16'h1;
      end
    end
    if (finish) begin
      next_s.mode = MODE_IDLE;
    end
    // event set wins over a simultaneous clear
    if (bus.wr_stb && bus.addr == ADDR_IRQ_STATUS) begin
      next_s.pass = s.pass & !bus.wdata[PASS_BIT];
      next_s.fail = s.fail & !bus.wdata[FAIL_BIT];
    end
    if (set_pass) begin
      next_s.pass = 1'b1;
    end
    if (set_fail) begin
      next_s.fail = 1'b1;
    end
    if (bus.wr_stb) begin
      unique case (bus.addr)
        ADDR_IRQ_ENABLE: next_s.irq_en = bus.wdata;
        ADDR_CLK_CFG:    next_s.clk_cfg = bus.wdata;
        ADDR_CH_SELECT:  next_s.sel = bus.wdata[NUM_CH-1:0];
        ADDR_INIT_VALUE: next_s.init = bus.wdata;
        ADDR_AVG_CTRL:   next_s.avg_en = bus.wdata[ENABLE_BIT];
        ADDR_CH_CTRL:    next_s.ch_en = bus.wdata[ENABLE_BIT];
        default:         next_s.irq_en = s.irq_en;
      endcase
    end
    if (start) begin
      next_s.mode       = start_avg ? MODE_AVG : MODE_CHAN;
      next_s.run_sel    = s.sel;
      next_s.cnt        = 16'(CAL_CYCLES - 1);
      next_s.fault_seen = '0;
      next_s.pass       = 1'b0;
      next_s.fail       = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{irq_en: RST_IRQ_ENABLE, pass: 1'b0, fail: 1'b0, avg_en: 1'b0, ch_en: 1'b0,
             clk_cfg: RST_CLK_CFG, sel: RST_CH_SELECT, init: RST_INIT_VALUE,
             mode: MODE_IDLE, cnt: 16'h0, run_sel: '0, fault_seen: '0, done: '0,
             err: '0};
    end else begin
      s <= next_s;
    end
  end

  assign cal_clk_en     = s.clk_cfg[CLK_RUN_BIT];
  assign cal_busy       = running;
  assign cal_active_ch  = running ? s.run_sel : '0;
  assign cal_init_value = s.init;
  assign irq = (s.pass && s.irq_en[PASS_BIT]) || (s.fail && s.irq_en[FAIL_BIT]);

  property p_flags_quiet_run;
    @(posedge clk) disable iff (!rst_b) running |-> !s.pass && !s.fail;
  endproperty
  a_flags_quiet_run: assert property (p_flags_quiet_run) else $error("flag set during run");

  property p_run_length;
    @(posedge clk) disable iff (!rst_b)
      start && clk_on ##1 clk_on [*8] |-> ##[493:495] !running;
  endproperty
  a_run_length: assert property (p_run_length) else $error("run length wrong");

  property p_result_once;
    @(posedge clk) disable iff (!rst_b) finish |=> !running && (s.pass ^ s.fail);
  endproperty
  a_result_once: assert property (p_result_once) else $error("no single result");

  property p_stay_idle;
    @(posedge clk) disable iff (!rst_b) !running && !start |=> !running;
  endproperty
  a_stay_idle: assert property (p_stay_idle) else $error("run without start");

  property p_pass_irq;
    @(posedge clk) disable iff (!rst_b) $rose(s.pass) && s.irq_en[PASS_BIT] |-> irq;
  endproperty
  a_pass_irq: assert property (p_pass_irq) else $error("pass event not raised");

  property p_masked_irq;
    @(posedge clk) disable iff (!rst_b) s.irq_en[7:6] == 2'b00 |-> !irq;
  endproperty
  a_masked_irq: assert property (p_masked_irq) else $error("masked event raised");

  property p_clear_pass;
    @(posedge clk) disable iff (!rst_b)
      bus.wr_stb && bus.addr == ADDR_IRQ_STATUS && bus.wdata[PASS_BIT] && !set_pass
      |=> !s.pass && s.fail == $past((s.fail && !bus.wdata[FAIL_BIT]) || set_fail);
  endproperty
  a_clear_pass: assert property (p_clear_pass) else $error("pass clear wrong");

  property p_chan_done;
    @(posedge clk) disable iff (!rst_b)
      finish && s.mode == MODE_CHAN |=> (s.done & $past(s.run_sel)) == $past(s.run_sel);
  endproperty
  a_chan_done: assert property (p_chan_done) else $error("channel done missing");

  property p_run_sel;
    @(posedge clk) disable iff (!rst_b) start |=> running && s.run_sel == $past(s.sel);
  endproperty
  a_run_sel: assert property (p_run_sel) else $error("wrong channels run");
endmodule : dac_self_calibration_ctrl

// ---- sim/spi_host_model.sv ----
// serial host model: frames register reads and writes towards the sequencer
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      cs_b,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_b
);
  import cal_pkg::*;
  // half period in clk cycles, well above the 3-flop sync span
  localparam int HALF = 8;
  // calibration only pays off for a planned output below 100 MHz
  localparam int PLAN_OUT_MHZ = 70;

  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    sdi  = 1'b1;
  end

  task automatic xfer(input logic rd_n_wr, input logic [14:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd_n_wr, addr, wdata};
    rdata = 8'h00;
    cs_b <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi <= frame[i];
      repeat (HALF) @(posedge clk);
      // undriven read data shows as unknown so a missing enable never matches
      if (i < 8) rdata[i] = sdo_oe_b ? 1'bx : sdo;
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    // released line carries the inverse of its last value
    sdi <= ~frame[0];
    repeat (HALF) @(posedge clk);
    cs_b <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [14:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    xfer(1'b0, addr, data, unused);
  endtask : wr

  task automatic rd(input logic [14:0] addr, output logic [7:0] data);
    xfer(1'b1, addr, 8'h00, data);
  endtask : rd

  // calibration clock, channel choice, initial value, enable then start
  task automatic start_cal(input logic [7:0] sel, input logic [14:0] ctrl,
                           input logic [7:0] clk_cfg);
    wr(ADDR_CLK_CFG, clk_cfg);
    wr(ADDR_CH_SELECT, sel);
    wr(ADDR_INIT_VALUE, 8'ha2);
    wr(ctrl, 8'h01);
    wr(ctrl, 8'h03);
  endtask : start_cal
endmodule : spi_host_model

// ---- sim/dac_self_calibration_ctrl_test.sv ----
// self-checking bench for the self-calibration sequencer
`timescale 1ns/1ps
module dac_self_calibration_ctrl_test;
  import cal_pkg::*;
  logic       clk;
  logic       rst_b;
  logic       sclk;
  logic       cs_b;
  logic       sdi;
  logic       sdo;
  logic       sdo_oe_b;
  logic [3:0] cmp_fault;
  logic       cal_clk_en;
  logic       cal_busy;
  logic [3:0] cal_active_ch;
  logic [7:0] cal_init_value;
  logic       irq;
  int         n_errors;
  int         total_checks;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  dac_self_calibration_ctrl i_dut (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo),
    .sdo_oe_b(sdo_oe_b), .cmp_fault(cmp_fault), .cal_clk_en(cal_clk_en),
    .cal_busy(cal_busy), .cal_active_ch(cal_active_ch), .cal_init_value(cal_init_value),
    .irq(irq)
  );

  spi_host_model i_host (
    .clk(clk), .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo), .sdo_oe_b(sdo_oe_b)
  );

  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_byte(name, {7'h00, exp}, {7'h00, got});
  endtask : check_bit

  task automatic rd_chk(input string name, input logic [14:0] addr, input logic [7:0] mask,
                        input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(addr, d);
    check_byte(name, exp, d & mask);
  endtask : rd_chk

  // bounded wait: a run is 500 clk, so 1000 means a hung sequencer
  // polled at the falling edge, where the state has settled
  task automatic wait_idle;
    for (int i = 0; i < 1000 && cal_busy !== 1'b0; i++) @(negedge clk);
    check_bit("cal_busy", 1'b0, cal_busy);
    @(posedge clk);
  endtask : wait_idle

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    cmp_fault = 4'h0;
    n_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge clk);
    check_bit("cal_clk_en", 1'b0, cal_clk_en);
    check_bit("irq", 1'b0, irq);
    check_byte("cal_init_value", 8'h00, cal_init_value);
    rd_chk("clk_cfg", ADDR_CLK_CFG, 8'hff, 8'h30);
    rd_chk("irq_enable", ADDR_IRQ_ENABLE, 8'hff, 8'h00);
    rd_chk("ch_select", ADDR_CH_SELECT, 8'h0f, 8'h00);
    rd_chk("status_idle", ADDR_IRQ_STATUS, 8'hc0, 8'h00);
    rd_chk("unmapped", 15'h100, 8'hff, 8'h00);
    i_host.wr(ADDR_IRQ_ENABLE, 8'hc0);
    rd_chk("irq_enable", ADDR_IRQ_ENABLE, 8'hff, 8'hc0);
    // averaged run over all four channels
    i_host.start_cal(8'h0f, ADDR_AVG_CTRL, 8'h38);
    check_bit("cal_clk_en", 1'b1, cal_clk_en);
    check_bit("cal_busy", 1'b1, cal_busy);
    check_byte("active_ch", 8'h0f, {4'h0, cal_active_ch});
    check_byte("cal_init_value", 8'ha2, cal_init_value);
    rd_chk("status_running", ADDR_IRQ_STATUS, 8'hc0, 8'h00);
    wait_idle();
    check_byte("active_idle", 8'h00, {4'h0, cal_active_ch});
    rd_chk("status_pass", ADDR_IRQ_STATUS, 8'hc0, 8'h80);
    rd_chk("avg_ctrl_idle", ADDR_AVG_CTRL, 8'h03, 8'h01);
    check_bit("irq_pass", 1'b1, irq);
    i_host.wr(ADDR_IRQ_STATUS, 8'h80);
    rd_chk("status_cleared", ADDR_IRQ_STATUS, 8'hc0, 8'h00);
    check_bit("irq_cleared", 1'b0, irq);
    i_host.wr(ADDR_CLK_CFG, 8'h30);
    check_bit("cal_clk_en", 1'b0, cal_clk_en);
    // per-channel run on channels 0 and 2, channel 2 reports a fault
    cmp_fault <= 4'b0100;
    i_host.start_cal(8'h05, ADDR_CH_CTRL, 8'h38);
    check_byte("active_ch", 8'h05, {4'h0, cal_active_ch});
    wait_idle();
    cmp_fault <= 4'h0;
    rd_chk("status_fail", ADDR_IRQ_STATUS, 8'hc0, 8'h40);
    check_bit("irq_fail", 1'b1, irq);
    i_host.wr(ADDR_IRQ_ENABLE, 8'h80);
    check_bit("irq_masked", 1'b0, irq);
    i_host.wr(ADDR_CH_SELECT, 8'h01);
    rd_chk("ch0_status", ADDR_CH_CTRL, 8'hf0, 8'h80);
    i_host.wr(ADDR_CH_SELECT, 8'h04);
    rd_chk("ch2_status", ADDR_CH_CTRL, 8'h70, 8'h10);
    // start with the calibration clock off ends at once with a failure
    i_host.wr(ADDR_IRQ_STATUS, 8'h40);
    rd_chk("status_cleared", ADDR_IRQ_STATUS, 8'hc0, 8'h00);
    i_host.start_cal(8'h02, ADDR_CH_CTRL, 8'h30);
    wait_idle();
    check_bit("cal_clk_en", 1'b0, cal_clk_en);
    rd_chk("status_abort", ADDR_IRQ_STATUS, 8'hc0, 8'h40);
    rd_chk("ch1_status", ADDR_CH_CTRL, 8'h70, 8'h20);
    finish_test();
  end
endmodule : dac_self_calibration_ctrl_test
